// >>> include/goalc_map.vh
// Register map, field positions, reset values and timing counts of the level-control bank
`ifndef GOALC_MAP_VH
`define GOALC_MAP_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define GOALC_ADDR_BG_GAIN 8'h1b
`define GOALC_ADDR_R_GAIN 8'h1c
`define GOALC_ADDR_B_OFS 8'h1e
`define GOALC_ADDR_G_OFS 8'h1f
`define GOALC_ADDR_R_OFS 8'h20
`define GOALC_ADDR_HS_START 8'h21
`define GOALC_ADDR_MISC 8'h22
`define GOALC_ADDR_LVL_EN 8'h26
`define GOALC_ADDR_LVL_FILT 8'h28
`define GOALC_ADDR_FINE_LSB 8'h29

// ----------------------------------------
// Reset values
// ----------------------------------------
`define GOALC_RST_BG_GAIN 8'h55
`define GOALC_RST_R_GAIN 8'h05
`define GOALC_RST_OFS 8'h20
`define GOALC_RST_HS_START 8'h09
`define GOALC_RST_MISC 8'h00
`define GOALC_RST_LVL_EN 8'h00
`define GOALC_RST_LVL_FILT 8'h00
`define GOALC_RST_FINE_LSB 8'h00

// ----------------------------------------
// Writable bit masks
// ----------------------------------------
`define GOALC_MASK_FULL 8'hff
`define GOALC_MASK_R_GAIN 8'h0f
`define GOALC_MASK_OFS 8'h3f
`define GOALC_MASK_MISC 8'h0a
`define GOALC_MASK_LVL_EN 8'h01
`define GOALC_MASK_LVL_FILT 8'h7f
`define GOALC_MASK_FINE_LSB 8'h3f

// ----------------------------------------
// Field positions and vertical coefficient limit
// ----------------------------------------
`define GOALC_BIT_PSEUDO_SYNC 3
`define GOALC_BIT_VS_SOURCE 1
`define GOALC_BIT_LVL_EN 0
`define GOALC_VCOEF_MAX 4'ha

// ----------------------------------------
// Timing
// ----------------------------------------
`define GOALC_PSEUDO_HOLD_MS 3
`define GOALC_CLK_KHZ 20000

`endif

// >>> hdl/goalc_level_loop.v
// Automatic level-control loop for one channel
`timescale 1ns/1ps
`include "goalc_map.vh"

module goalc_level_loop (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Control
    input wire enable_i,
    input wire [2:0] hcoef_i,
    input wire [3:0] vcoef_i,
    input wire [9:0] base_offset_i,
    // Pixel stream
    input wire line_start_i,
    input wire blank_valid_i,
    input wire [9:0] sample_i,
    input wire [9:0] target_i,
    // Result
    output reg [9:0] offset_o
);

    // ----------------------------------------
    // Horizontal average over 2^(code+1) samples
    // ----------------------------------------
    reg [17:0] acc;
    reg [8:0] count;
    reg done;
    reg signed [17:0] corr;
    wire [8:0] need = 9'h002 << hcoef_i;
    wire [3:0] hshift = {1'b0, hcoef_i} + 4'h1;
    wire [3:0] vshift = (vcoef_i > `GOALC_VCOEF_MAX) ? `GOALC_VCOEF_MAX : vcoef_i;
    wire [17:0] avg = acc >> hshift;
    wire signed [17:0] err = $signed({8'h00, target_i}) - $signed(avg);
    wire signed [17:0] step = err >>> vshift;
    wire signed [17:0] sum = $signed({8'h00, base_offset_i}) + corr;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            acc <= 18'h00000;
            count <= 9'h000;
            done <= 1'b0;
            corr <= 18'sh00000;
            offset_o <= 10'h000;
        end else begin
            if (!enable_i) begin
                corr <= 18'sh00000;
                acc <= 18'h00000;
                count <= 9'h000;
                done <= 1'b0;
            end else if (line_start_i) begin
                acc <= 18'h00000;
                count <= 9'h000;
                done <= 1'b0;
            end else if (blank_valid_i && !done) begin
                acc <= acc + {8'h00, sample_i};
                count <= count + 9'h001;
                if (count + 9'h001 == need) begin
                    done <= 1'b1;
                end
            end else if (done && count != 9'h000) begin
                corr <= corr + step;
                count <= 9'h000;
            end
            if (sum < 0) begin
                offset_o <= 10'h000;
            end else if (sum > 18'sh003ff) begin
                offset_o <= 10'h3ff;
            end else begin
                offset_o <= sum[9:0];
            end
        end
    end

endmodule

// >>> hdl/goalc_regs.v
// Gain, offset, sync and level-control register bank with its level loops
`timescale 1ns/1ps
`include "goalc_map.vh"

module goalc_regs (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Register port from the serial slave
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    // Video timing
    input wire line_start_i,
    input wire [7:0] pixel_count_i,
    input wire vsync_sep_i,
    input wire vsync_counter_i,
    // Blank-level samples per channel
    input wire blank_valid_i,
    input wire [9:0] red_sample_i,
    input wire [9:0] green_sample_i,
    input wire [9:0] blue_sample_i,
    input wire [9:0] level_target_i,
    // Analog control outputs
    output reg [3:0] red_gain_o,
    output reg [3:0] green_gain_o,
    output reg [3:0] blue_gain_o,
    output wire [9:0] red_offset_o,
    output wire [9:0] green_offset_o,
    output wire [9:0] blue_offset_o,
    // Sync outputs
    output reg hsync_output_o,
    output reg vsync_output_o,
    output reg pseudo_sync_compat_en_o,
    output reg pseudo_sync_ready_o
);

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    reg [7:0] blue_green_coarse_gain;
    reg [7:0] red_coarse_gain;
    reg [7:0] blue_coarse_offset;
    reg [7:0] green_coarse_offset;
    reg [7:0] red_coarse_offset;
    reg [7:0] hsync_out_start_pixel;
    reg [7:0] misc_sync_control;
    reg [7:0] level_control_enable;
    reg [7:0] level_control_filter;
    reg [7:0] fine_offset_low_bits;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            blue_green_coarse_gain <= `GOALC_RST_BG_GAIN;
            red_coarse_gain <= `GOALC_RST_R_GAIN;
            blue_coarse_offset <= `GOALC_RST_OFS;
            green_coarse_offset <= `GOALC_RST_OFS;
            red_coarse_offset <= `GOALC_RST_OFS;
            hsync_out_start_pixel <= `GOALC_RST_HS_START;
            misc_sync_control <= `GOALC_RST_MISC;
            level_control_enable <= `GOALC_RST_LVL_EN;
            level_control_filter <= `GOALC_RST_LVL_FILT;
            fine_offset_low_bits <= `GOALC_RST_FINE_LSB;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `GOALC_ADDR_BG_GAIN: blue_green_coarse_gain <= reg_wdata_i;
                `GOALC_ADDR_R_GAIN: red_coarse_gain <= reg_wdata_i & `GOALC_MASK_R_GAIN;
                `GOALC_ADDR_B_OFS: blue_coarse_offset <= reg_wdata_i & `GOALC_MASK_OFS;
                `GOALC_ADDR_G_OFS: green_coarse_offset <= reg_wdata_i & `GOALC_MASK_OFS;
                `GOALC_ADDR_R_OFS: red_coarse_offset <= reg_wdata_i & `GOALC_MASK_OFS;
                `GOALC_ADDR_HS_START: hsync_out_start_pixel <= reg_wdata_i;
                `GOALC_ADDR_MISC: misc_sync_control <= reg_wdata_i & `GOALC_MASK_MISC;
                `GOALC_ADDR_LVL_EN: level_control_enable <= reg_wdata_i & `GOALC_MASK_LVL_EN;
                `GOALC_ADDR_LVL_FILT: level_control_filter <= reg_wdata_i & `GOALC_MASK_LVL_FILT;
                `GOALC_ADDR_FINE_LSB: fine_offset_low_bits <= reg_wdata_i & `GOALC_MASK_FINE_LSB;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                `GOALC_ADDR_BG_GAIN: reg_rdata_o <= blue_green_coarse_gain;
                `GOALC_ADDR_R_GAIN: reg_rdata_o <= red_coarse_gain;
                `GOALC_ADDR_B_OFS: reg_rdata_o <= blue_coarse_offset;
                `GOALC_ADDR_G_OFS: reg_rdata_o <= green_coarse_offset;
                `GOALC_ADDR_R_OFS: reg_rdata_o <= red_coarse_offset;
                `GOALC_ADDR_HS_START: reg_rdata_o <= hsync_out_start_pixel;
                `GOALC_ADDR_MISC: reg_rdata_o <= misc_sync_control;
                `GOALC_ADDR_LVL_EN: reg_rdata_o <= level_control_enable;
                `GOALC_ADDR_LVL_FILT: reg_rdata_o <= level_control_filter;
                `GOALC_ADDR_FINE_LSB: reg_rdata_o <= fine_offset_low_bits;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Line-boundary shadow of analog and level-control settings
    // ----------------------------------------
    reg [5:0] red_ofs_act;
    reg [5:0] green_ofs_act;
    reg [5:0] blue_ofs_act;
    reg [5:0] fine_act;
    reg [6:0] filt_act;
    reg lvl_en_act;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            red_gain_o <= 4'h5;
            green_gain_o <= 4'h5;
            blue_gain_o <= 4'h5;
            red_ofs_act <= 6'h20;
            green_ofs_act <= 6'h20;
            blue_ofs_act <= 6'h20;
            fine_act <= 6'h00;
            filt_act <= 7'h00;
            lvl_en_act <= 1'b0;
        end else if (line_start_i) begin
            green_gain_o <= blue_green_coarse_gain[7:4];
            blue_gain_o <= blue_green_coarse_gain[3:0];
            red_gain_o <= red_coarse_gain[3:0];
            red_ofs_act <= red_coarse_offset[5:0];
            green_ofs_act <= green_coarse_offset[5:0];
            blue_ofs_act <= blue_coarse_offset[5:0];
            fine_act <= fine_offset_low_bits[5:0];
            filt_act <= level_control_filter[6:0];
            lvl_en_act <= level_control_enable[`GOALC_BIT_LVL_EN];
        end
    end

    // ----------------------------------------
    // Offset base: coarse code in four-step units plus fine bits
    // ----------------------------------------
    function [9:0] goalc_base;
        input [5:0] coarse;
        input [1:0] fine;
        reg [9:0] mag;
        begin
            mag = {3'b000, coarse[4:0], 2'b00};
            if (coarse[5]) begin
                goalc_base = (10'h1fc - mag) | {8'h00, fine};
            end else begin
                goalc_base = (10'h200 + mag) | {8'h00, fine};
            end
        end
    endfunction

    wire [9:0] red_base = goalc_base(red_ofs_act, fine_act[5:4]);
    wire [9:0] green_base = goalc_base(green_ofs_act, fine_act[3:2]);
    wire [9:0] blue_base = goalc_base(blue_ofs_act, fine_act[1:0]);

    // ----------------------------------------
    // Level loops per channel
    // ----------------------------------------
    goalc_level_loop u_red (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .enable_i(lvl_en_act),
        .hcoef_i(filt_act[2:0]),
        .vcoef_i(filt_act[6:3]),
        .base_offset_i(red_base),
        .line_start_i(line_start_i),
        .blank_valid_i(blank_valid_i),
        .sample_i(red_sample_i),
        .target_i(level_target_i),
        .offset_o(red_offset_o)
    );

    goalc_level_loop u_green (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .enable_i(lvl_en_act),
        .hcoef_i(filt_act[2:0]),
        .vcoef_i(filt_act[6:3]),
        .base_offset_i(green_base),
        .line_start_i(line_start_i),
        .blank_valid_i(blank_valid_i),
        .sample_i(green_sample_i),
        .target_i(level_target_i),
        .offset_o(green_offset_o)
    );

    goalc_level_loop u_blue (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .enable_i(lvl_en_act),
        .hcoef_i(filt_act[2:0]),
        .vcoef_i(filt_act[6:3]),
        .base_offset_i(blue_base),
        .line_start_i(line_start_i),
        .blank_valid_i(blank_valid_i),
        .sample_i(blue_sample_i),
        .target_i(level_target_i),
        .offset_o(blue_offset_o)
    );

    // ----------------------------------------
    // Sync outputs
    // ----------------------------------------
    reg vsep_meta;
    reg vsep_sync;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vsep_meta <= 1'b0;
            vsep_sync <= 1'b0;
            hsync_output_o <= 1'b0;
            vsync_output_o <= 1'b0;
            pseudo_sync_compat_en_o <= 1'b0;
        end else begin
            vsep_meta <= vsync_sep_i;
            vsep_sync <= vsep_meta;
            if (line_start_i) begin
                hsync_output_o <= 1'b0;
            end else if (pixel_count_i == hsync_out_start_pixel) begin
                hsync_output_o <= 1'b1;
            end
            if (misc_sync_control[`GOALC_BIT_VS_SOURCE]) begin
                vsync_output_o <= vsep_sync;
            end else begin
                vsync_output_o <= vsep_sync & vsync_counter_i;
            end
            pseudo_sync_compat_en_o <= misc_sync_control[`GOALC_BIT_PSEUDO_SYNC];
        end
    end

    // ----------------------------------------
    // Pseudo-sync hold timer: reports when the low time has been met
    // ----------------------------------------
    localparam [31:0] HOLD_CYCLES = `GOALC_PSEUDO_HOLD_MS * `GOALC_CLK_KHZ;
    reg [15:0] hold_count;

    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hold_count <= 16'h0000;
            pseudo_sync_ready_o <= 1'b0;
        end else if (misc_sync_control[`GOALC_BIT_PSEUDO_SYNC]) begin
            hold_count <= 16'h0000;
            pseudo_sync_ready_o <= 1'b0;
        end else if ({16'h0000, hold_count} < HOLD_CYCLES - 32'd1) begin
            hold_count <= hold_count + 16'h0001;
        end else begin
            pseudo_sync_ready_o <= 1'b1;
        end
    end

endmodule

// >>> dv/goalc_chk.sv
// Port assertions for the register bank
`timescale 1ns/1ps
module goalc_chk (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_i,
    // Register port
    input wire reg_wr_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire [7:0] reg_rdata_o,
    // Timing inputs
    input wire line_start_i,
    input wire [7:0] pixel_count_i,
    input wire vsync_sep_i,
    input wire vsync_counter_i,
    // Observed outputs
    input wire [3:0] red_gain_o,
    input wire [3:0] green_gain_o,
    input wire [3:0] blue_gain_o,
    input wire hsync_output_o,
    input wire vsync_output_o,
    input wire pseudo_sync_compat_en_o,
    input wire pseudo_sync_ready_o
);
    reg [7:0] hs;
    reg src;
    reg [15:0] low_cnt;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ----------------------------------------
    // Shadow of host-written fields and count of cycles with compat enable low
    // ----------------------------------------
    always @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hs <= 8'h09;
            src <= 1'b0;
            low_cnt <= 16'h0000;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'h21) begin
                hs <= reg_wdata_i;
            end
            if (reg_wr_i && reg_addr_i == 8'h22) begin
                src <= reg_wdata_i[1];
            end
            if (pseudo_sync_compat_en_o) begin
                low_cnt <= 16'h0000;
            end else if (low_cnt != 16'hffff) begin
                low_cnt <= low_cnt + 16'h0001;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_hs_set;
        !line_start_i && pixel_count_i == hs |=> hsync_output_o;
    endproperty
    property p_hs_clr;
        line_start_i && pixel_count_i != hs |=> !hsync_output_o;
    endproperty
    property p_compat;
        reg_wr_i && reg_addr_i == 8'h22 |=> ##1
            pseudo_sync_compat_en_o == $past(reg_wdata_i[3], 2);
    endproperty
    property p_vs_dir;
        (src && vsync_sep_i) [*4] |-> vsync_output_o;
    endproperty
    property p_vs_cnt;
        (!src && !vsync_counter_i) [*4] |-> !vsync_output_o;
    endproperty
    property p_gain;
        !$stable({red_gain_o, green_gain_o, blue_gain_o}) |-> $past(line_start_i);
    endproperty
    property p_rdback;
        reg_wr_i && reg_addr_i == 8'h1c ##1 !reg_wr_i && reg_addr_i == 8'h1c
            |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h0f);
    endproperty
    property p_unmap;
        reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00;
    endproperty
    property p_rdy_early;
        pseudo_sync_ready_o && !pseudo_sync_compat_en_o |-> low_cnt > 16'd59990;
    endproperty
    property p_rdy_late;
        low_cnt == 16'd60010 |-> pseudo_sync_ready_o;
    endproperty
    a_hs_set: assert property (p_hs_set) else $error("hsync not set");
    a_hs_clr: assert property (p_hs_clr) else $error("hsync not cleared");
    a_compat: assert property (p_compat) else $error("compat enable wrong");
    a_vs_dir: assert property (p_vs_dir) else $error("direct vsync wrong");
    a_vs_cnt: assert property (p_vs_cnt) else $error("counter vsync wrong");
    a_gain: assert property (p_gain) else $error("gain off line start");
    a_rdback: assert property (p_rdback) else $error("readback wrong");
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    a_rdy_early: assert property (p_rdy_early) else $error("ready early");
    a_rdy_late: assert property (p_rdy_late) else $error("ready late");
    c_gain: cover property (!$stable(red_gain_o));
    c_ready: cover property ($rose(pseudo_sync_ready_o));
    c_vs: cover property (src && vsync_output_o);
endmodule

// >>> dv/goalc_host.sv
// Host model driving the register port
`timescale 1ns/1ps
module goalc_host (
    // Clock
    input wire ref_clk_i,
    // Register port
    output reg reg_wr_o,
    output reg [7:0] reg_addr_o,
    output reg [7:0] reg_wdata_o,
    input wire [7:0] reg_rdata_i
);
    integer low_cycles = 0;
    reg compat_req = 1'b0;
    initial begin
        reg_wr_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end
    always @(posedge ref_clk_i) begin
        low_cycles <= compat_req ? 0 : low_cycles + 1;
    end
    task wr(input [7:0] a, input [7:0] d);
        begin
            if (a == 8'h22 && d[3] && !compat_req) begin
                while (low_cycles < 60100) @(posedge ref_clk_i);
            end
            @(posedge ref_clk_i);
            reg_wr_o <= 1'b1;
            reg_addr_o <= a;
            reg_wdata_o <= d;
            @(posedge ref_clk_i);
            reg_wr_o <= 1'b0;
            reg_wdata_o <= ~d;
            if (a == 8'h22) compat_req = d[3];
        end
    endtask
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge ref_clk_i);
            reg_addr_o <= a;
            @(posedge ref_clk_i);
            #1;
            d = reg_rdata_i;
        end
    endtask
endmodule

// >>> dv/goalc_regs_bench.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
`include "goalc_map.vh"
module goalc_regs_bench;
    reg ref_clk_i = 1'b0;
    reg reset_i = 1'b1;
    reg line_start = 1'b0;
    reg [7:0] pix = 8'h00;
    reg vs_sep = 1'b0;
    reg vs_cnt = 1'b0;
    reg blank = 1'b0;
    reg [9:0] rs = 10'h1c0;
    reg [9:0] tgt = 10'h200;
    wire wr;
    wire [7:0] addr, wdata, rdata;
    wire [3:0] rg, gg, bg;
    wire [9:0] ro, go, bo;
    wire hso, vso, cen, rdy;
    integer n_fail = 0, checks = 0, cyc = 0, i, k;
    reg [7:0] d, v, v2;
    reg [1:0] f;
    reg [9:0] bsn;
    localparam logic [7:0] AD [10] = '{8'h1b, 8'h1c, 8'h1e, 8'h1f, 8'h20, 8'h21,
        8'h22, 8'h26, 8'h28, `GOALC_ADDR_FINE_LSB};
    localparam logic [7:0] RV [10] = '{8'h55, 8'h05, 8'h20, 8'h20, 8'h20, 8'h09,
        8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MK [10] = '{8'hff, 8'h0f, 8'h3f, 8'h3f, 8'h3f, 8'hff,
        8'h0a, 8'h01, 8'h7f, 8'h3f};
    localparam logic [5:0] CO [5] = '{6'h00, 6'h01, 6'h1f, 6'h20, 6'h3f};
    localparam logic [6:0] HV [5] = '{7'h00, 7'h19, 7'h33, 7'h52, 7'h78};
    localparam logic [9:0] DL [5] = '{10'h040, 10'h008, 10'h001, 10'h000, 10'h000};
    goalc_host host (.ref_clk_i(ref_clk_i), .reg_wr_o(wr), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata));
    goalc_regs dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .line_start_i(line_start), .pixel_count_i(pix), .vsync_sep_i(vs_sep),
        .vsync_counter_i(vs_cnt), .blank_valid_i(blank), .red_sample_i(rs),
        .green_sample_i(tgt), .blue_sample_i(rs), .level_target_i(tgt),
        .red_gain_o(rg), .green_gain_o(gg), .blue_gain_o(bg), .red_offset_o(ro),
        .green_offset_o(go), .blue_offset_o(bo), .hsync_output_o(hso),
        .vsync_output_o(vso), .pseudo_sync_compat_en_o(cen), .pseudo_sync_ready_o(rdy));
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        pix <= pix + 8'h01;
        line_start <= (pix == 8'hfe);
        blank <= (pix >= 8'h0f && pix < 8'h1f);
        vs_sep <= $urandom % 2;
        vs_cnt <= $urandom % 2;
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_fail = n_fail + 1;
            close_out;
        end
    end
    function [9:0] exp_ofs(input [5:0] c, input [1:0] fl);
        begin
            if (c[5]) exp_ofs = 10'h1fc - {3'h0, c[4:0], 2'b00} + fl;
            else exp_ofs = 10'h200 + {3'h0, c[4:0], 2'b00} + fl;
        end
    endfunction
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checks = checks + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wait_line;
        begin
            @(posedge ref_clk_i);
            while (line_start !== 1'b1) @(posedge ref_clk_i);
            repeat (3) @(posedge ref_clk_i);
            #1;
        end
    endtask
    task close_out;
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
            else $display("TESTS FAILED");
            $finish;
        end
    endtask
    initial begin
        void'($urandom(32'h938c));
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        for (i = 0; i < 10; i = i + 1) begin
            host.rd(AD[i], d);
            check(d, RV[i]);
        end
        check(rdy, 0);
        v = $urandom;
        v2 = $urandom;
        while (pix != 8'h40) @(posedge ref_clk_i);
        host.wr(8'h1b, v);
        host.wr(8'h1c, v2);
        check({rg, gg, bg}, 12'h555);
        wait_line;
        check({rg, gg, bg}, {v2[3:0], v});
        for (i = 0; i < 40; i = i + 1) begin
            k = $urandom % 10;
            v = $urandom;
            if (k == 6) v = v & 8'hf7;
            host.wr(AD[k], v);
            host.rd(AD[k], d);
            check(d, v & MK[k]);
        end
        host.rd(8'h00, d);
        check(d, 0);
        host.rd(8'h1d, d);
        check(d, 0);
        host.wr(8'h26, 8'h00);
        for (i = 0; i < 5; i = i + 1) begin
            f = $urandom;
            host.wr(8'h1e, CO[i]);
            host.wr(8'h1f, CO[(i + 1) % 5]);
            host.wr(8'h20, CO[(i + 2) % 5]);
            host.wr(`GOALC_ADDR_FINE_LSB, {2'b00, f, ~f, f});
            wait_line;
            check(bo, exp_ofs(CO[i], f));
            check(go, exp_ofs(CO[(i + 1) % 5], ~f));
            check(ro, exp_ofs(CO[(i + 2) % 5], f));
        end
        host.wr(8'h26, 8'h01);
        for (i = 0; i < 5; i = i + 1) begin
            host.wr(8'h28, {1'b0, HV[i]});
            wait_line;
            v2 = go[7:0];
            {d, f} = ro;
            bsn = bo;
            wait_line;
            check(ro - {d, f}, DL[i]);
            check(go[7:0], v2);
            check(bo - bsn, DL[i]);
        end
        host.wr(8'h22, 8'h02);
        repeat (60100) @(posedge ref_clk_i);
        #1;
        check(rdy, 1);
        host.wr(8'h22, 8'h0a);
        repeat (2) @(posedge ref_clk_i);
        #1;
        check(cen, 1);
        close_out;
    end
endmodule
bind goalc_regs goalc_chk u_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .line_start_i(line_start_i),
    .pixel_count_i(pixel_count_i), .vsync_sep_i(vsync_sep_i),
    .vsync_counter_i(vsync_counter_i), .red_gain_o(red_gain_o),
    .green_gain_o(green_gain_o), .blue_gain_o(blue_gain_o),
    .hsync_output_o(hsync_output_o), .vsync_output_o(vsync_output_o),
    .pseudo_sync_compat_en_o(pseudo_sync_compat_en_o),
    .pseudo_sync_ready_o(pseudo_sync_ready_o));
